// file: rtl/serial_port_top.sv
// Four-mode serial port: synchronous shift mode and three UART modes,
// registers on APB. Assumes timer overflow pulses on the core clock and
// an external pull-up on the open-drain data pin.
`timescale 1ns/1ps
`default_nettype none
module serial_port_top
   import serial_port_pkg::*;
(
   input wire logic REF_CLK, // Core clock, 100 MHz
   input wire logic RESETN, // Asynchronous reset, active low
   input wire logic PSEL, // APB select
   input wire logic PENABLE, // APB access phase
   input wire logic PWRITE, // APB direction
   input wire logic [7:0] PADDR, // APB byte address
   input wire logic [31:0] PWDATA, // APB write data
   output logic [31:0] PRDATA, // APB read data
   output logic PREADY, // APB ready
   output logic PSLVERR, // APB error, unmapped address
   input wire logic TIMER1_OVF, // Timer 1 overflow pulse
   input wire logic TIMER234_OVF, // Timer 2/3/4 overflow pulse
   input wire logic SERIAL_IN_PIN, // Data pin level
   output logic SERIAL_IN_OUT, // Data pin drive value
   output logic SERIAL_IN_OE, // Data pin drive enable
   output logic SERIAL_OUT_PIN, // Transmit data or shift clock
   output logic IRQ // Interrupt request, level
);
   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic irq;
      logic [7:0] ctrl;
      logic [2:0] baud;
      logic [3:0] stat;
      logic [3:0] mask;
      logic [7:0] saddr;
      logic [7:0] saden;
      logic [7:0] hold;
      logic unread;
      tx_state_t txs;
      logic [10:0] tsh;
      logic [3:0] tbits;
      logic [3:0] tsub;
      logic [3:0] m0div;
      logic m0rx;
      rx_state_t rxs;
      logic [8:0] rsh;
      logic [3:0] rbits;
      logic [3:0] rsub;
      logic out_pin;
      logic io_out;
      logic io_oe;
   } st_t;

   st_t st_q;
   st_t st_d;
   logic rxv;
   logic acc;
   logic wr;
   logic rd;
   logic wr_ctrl;
   logic hit;
   logic [1:0] mode;
   logic nine;
   logic match;
   logic tx_tick;
   logic rx_tick;

   ////////////////////////////////////////////////////////////////////////
   // Pin synchroniser and tick generators

   tick_if tx_if ();
   tick_if rx_if ();

   line_sync u_sync
   (
      .clk(REF_CLK),
      .rst_n(RESETN),
      .pin(SERIAL_IN_PIN),
      .level(rxv)
   );

   // Transmit and receive rate sources are chosen separately
   assign tx_if.t1_ovf = TIMER1_OVF;
   assign tx_if.t234_ovf = TIMER234_OVF;
   assign tx_if.fixed_rate = (mode == MODE_UART9F);
   assign tx_if.src_sel = st_q.baud[BAUD_TXSRC];
   assign tx_if.dbl = st_q.baud[BAUD_DBL];
   assign rx_if.t1_ovf = TIMER1_OVF;
   assign rx_if.t234_ovf = TIMER234_OVF;
   assign rx_if.fixed_rate = (mode == MODE_UART9F);
   assign rx_if.src_sel = st_q.baud[BAUD_RXSRC];
   assign rx_if.dbl = st_q.baud[BAUD_DBL];
   assign tx_tick = tx_if.tick;
   assign rx_tick = rx_if.tick;

   tick_gen u_tx_tick
   (
      .clk(REF_CLK),
      .rst_n(RESETN),
      .tif(tx_if.gen)
   );

   tick_gen u_rx_tick
   (
      .clk(REF_CLK),
      .rst_n(RESETN),
      .tif(rx_if.gen)
   );

   ////////////////////////////////////////////////////////////////////////
   // Decode

   assign mode = st_q.ctrl[CTL_MODE +: 2];
   assign nine = mode[1];
   assign match = ((st_q.rsh[7:0] ^ st_q.saddr) & st_q.saden) == 8'h00;
   assign acc = PSEL && PENABLE;
   // Writes and read side effects act only at the completing edge
   assign wr = acc && st_q.pready && PWRITE;
   assign rd = acc && st_q.pready && !PWRITE;
   assign wr_ctrl = wr && (PADDR == OFS_CTRL);
   assign hit = PADDR inside {OFS_CTRL, OFS_DATA, OFS_BAUD, OFS_STAT,
                              OFS_MASK, OFS_ADDR, OFS_ADEN};

   assign PRDATA = st_q.prdata;
   assign PREADY = st_q.pready;
   assign PSLVERR = st_q.pslverr;
   assign IRQ = st_q.irq;
   assign SERIAL_OUT_PIN = st_q.out_pin;
   assign SERIAL_IN_OUT = st_q.io_out;
   assign SERIAL_IN_OE = st_q.io_oe;

   ////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb
   begin
      logic tx_load;
      logic ti_set;
      logic rx_done;
      logic accept;
      logic [7:0] rx_data;
      logic rx_b9;
      logic [3:0] n_pre;
      logic [3:0] n_data;
      tx_load = 1'b0;
      ti_set = 1'b0;
      rx_done = 1'b0;
      accept = 1'b0;
      rx_data = st_q.rsh[8:1];
      rx_b9 = rxv;
      n_pre = nine ? TX_PRE9 : TX_PRE8;
      n_data = nine ? RX_DATA9 : RX_DATA8;
      st_d = st_q;

      // One wait state: data captured in the first access cycle
      st_d.pready = acc && !st_q.pready;
      st_d.pslverr = 1'b0;
      st_d.prdata = 32'h0000_0000;
      if (acc && !st_q.pready)
      begin
         st_d.pslverr = !hit;
         case (PADDR)
            OFS_CTRL: st_d.prdata = {24'h00_0000, st_q.ctrl};
            OFS_DATA: st_d.prdata = {24'h00_0000, st_q.hold};
            OFS_BAUD: st_d.prdata = {29'h0000_0000, st_q.baud};
            OFS_STAT: st_d.prdata = {28'h000_0000, st_q.stat};
            OFS_MASK: st_d.prdata = {28'h000_0000, st_q.mask};
            OFS_ADDR: st_d.prdata = {24'h00_0000, st_q.saddr};
            OFS_ADEN: st_d.prdata = {24'h00_0000, st_q.saden};
            default: st_d.prdata = 32'h0000_0000;
         endcase
      end
      if (wr)
      begin
         case (PADDR)
            OFS_CTRL:
            begin
               st_d.ctrl = PWDATA[7:0];
               st_d.ctrl[CTL_RB8] = st_q.ctrl[CTL_RB8];
            end
            OFS_DATA: tx_load = 1'b1;
            OFS_BAUD: st_d.baud = PWDATA[2:0];
            OFS_MASK: st_d.mask = PWDATA[3:0];
            OFS_ADDR: st_d.saddr = PWDATA[7:0];
            OFS_ADEN: st_d.saden = PWDATA[7:0];
            default: st_d.mask = st_q.mask;
         endcase
      end
      // Clear only the bits the read returned, so a late event survives
      if (rd && PADDR == OFS_STAT)
         st_d.stat = st_q.stat & ~st_q.prdata[3:0];
      if (rd && PADDR == OFS_DATA)
         st_d.unread = 1'b0;

      // Transmitter, also the mode 0 shift engine for both directions
      case (st_q.txs)
         TX_IDLE:
         begin
            st_d.m0div = 4'h0;
            st_d.tbits = 4'h0;
            st_d.tsub = 4'h0;
            if (tx_load && mode == MODE_SYNC)
            begin
               st_d.txs = TX_SYNC;
               st_d.tsh = {3'h7, PWDATA[7:0]};
               st_d.m0rx = 1'b0;
            end
            else if (tx_load)
            begin
               st_d.txs = TX_UART;
               st_d.tsh = {1'b1, nine ? st_q.ctrl[CTL_TB8] : 1'b1,
                           PWDATA[7:0], 1'b0};
            end
            else if (mode == MODE_SYNC && st_q.ctrl[CTL_REN] &&
                     !st_q.ctrl[CTL_RI])
            begin
               st_d.txs = TX_SYNC;
               st_d.tsh = 11'h7FF;
               st_d.m0rx = 1'b1;
            end
         end
         TX_UART:
         begin
            if (tx_tick)
            begin
               st_d.tsub = st_q.tsub + 4'h1;
               if (st_q.tsub == OVS_LAST)
               begin
                  st_d.tsh = {1'b1, st_q.tsh[10:1]};
                  st_d.tbits = st_q.tbits + 4'h1;
                  // Done at the start of the stop bit
                  ti_set = (st_q.tbits + 4'h1 == n_pre);
                  if (st_q.tbits == n_pre)
                     st_d.txs = TX_IDLE;
               end
            end
         end
         TX_SYNC:
         begin
            // Fixed twelve-cycle shift clock: low half, then high half
            st_d.m0div = (st_q.m0div == M0_LAST) ? 4'h0 :
                         st_q.m0div + 4'h1;
            if (st_q.m0div == M0_HALF && st_q.m0rx)
               st_d.rsh = {rxv, st_q.rsh[8:1]};
            if (st_q.m0div == M0_LAST)
            begin
               st_d.tsh = {1'b1, st_q.tsh[10:1]};
               st_d.tbits = st_q.tbits + 4'h1;
               if (st_q.tbits == M0_BITS_LAST)
               begin
                  st_d.txs = TX_IDLE;
                  ti_set = !st_q.m0rx;
                  rx_done = st_q.m0rx;
                  accept = st_q.m0rx && !st_q.ctrl[CTL_RI];
                  rx_b9 = st_q.ctrl[CTL_RB8];
               end
            end
         end
         default: st_d.txs = TX_IDLE;
      endcase

      // Asynchronous receiver, independent of the transmitter
      case (st_q.rxs)
         RX_IDLE:
         begin
            st_d.rsub = 4'h0;
            st_d.rbits = 4'h0;
            if (mode != MODE_SYNC && st_q.ctrl[CTL_REN] && !rxv)
               st_d.rxs = RX_START;
         end
         RX_START:
         begin
            if (rx_tick)
            begin
               st_d.rsub = st_q.rsub + 4'h1;
               // A glitch shorter than half a bit is dropped
               if (st_q.rsub == OVS_MID)
               begin
                  st_d.rsub = 4'h0;
                  st_d.rxs = rxv ? RX_IDLE : RX_DATA;
               end
            end
         end
         RX_DATA:
         begin
            if (rx_tick)
            begin
               st_d.rsub = st_q.rsub + 4'h1;
               if (st_q.rsub == OVS_LAST)
               begin
                  st_d.rsh = {rxv, st_q.rsh[8:1]};
                  st_d.rbits = st_q.rbits + 4'h1;
                  if (st_q.rbits + 4'h1 == n_data)
                     st_d.rxs = RX_STOP;
               end
            end
         end
         RX_STOP:
         begin
            if (rx_tick)
            begin
               st_d.rsub = st_q.rsub + 4'h1;
               if (st_q.rsub == OVS_LAST)
               begin
                  st_d.rxs = RX_IDLE;
                  rx_done = 1'b1;
                  if (!rxv)
                     st_d.stat[ST_FERR] = 1'b1;
                  if (nine)
                  begin
                     rx_data = st_q.rsh[7:0];
                     rx_b9 = st_q.rsh[8];
                     accept = !st_q.ctrl[CTL_RI] &&
                              (!st_q.ctrl[CTL_SM2] ||
                               (st_q.rsh[8] && match));
                  end
                  else
                     accept = !st_q.ctrl[CTL_RI] &&
                              (!st_q.ctrl[CTL_SM2] || rxv);
               end
            end
         end
         default: st_d.rxs = RX_IDLE;
      endcase

      // Flag sets come after software writes and clears, so a set wins
      if (ti_set)
      begin
         st_d.ctrl[CTL_TI] = 1'b1;
         st_d.stat[ST_TX] = 1'b1;
      end
      if (rx_done && accept)
      begin
         st_d.hold = rx_data;
         st_d.ctrl[CTL_RB8] = rx_b9;
         st_d.ctrl[CTL_RI] = 1'b1;
         st_d.stat[ST_RX] = 1'b1;
         if (st_d.unread)
            st_d.stat[ST_OVR] = 1'b1;
         st_d.unread = 1'b1;
      end

      // Pins follow the next state so they stay in step with it
      if (st_d.txs == TX_SYNC)
         st_d.out_pin = (st_d.m0div >= M0_HALF);
      else if (st_d.txs == TX_UART)
         st_d.out_pin = st_d.tsh[0];
      else
         st_d.out_pin = 1'b1;
      st_d.io_out = 1'b0;
      // Open drain: only a zero is driven, the pull-up makes the one
      st_d.io_oe = (st_d.txs == TX_SYNC) && !st_d.m0rx && !st_d.tsh[0];
      st_d.irq = |(st_d.stat & st_d.mask);
   end

   always_ff @(posedge REF_CLK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         st_q <= '0;
         st_q.ctrl <= CTRL_RST;
         st_q.baud <= BAUD_RST;
         st_q.stat <= STAT_RST;
         st_q.saddr <= ADDR_RST;
         st_q.saden <= ADDR_RST;
         st_q.txs <= TX_IDLE;
         st_q.rxs <= RX_IDLE;
         st_q.out_pin <= 1'b1;
      end
      else
         st_q <= st_d;
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (!RESETN);

   a_apb_one_wait: assert property (
      acc && !PREADY |=> PREADY ##1 !PREADY)
      else $error("APB answer not after one wait");
   a_ti_from_tx: assert property (
      $rose(st_q.ctrl[CTL_TI]) && !$past(wr_ctrl) |->
      $past(st_q.txs) != TX_IDLE)
      else $error("Transmit flag set without a transfer");
   a_flags_sticky: assert property (
      st_q.ctrl[CTL_RI] && !wr_ctrl |=> st_q.ctrl[CTL_RI])
      else $error("Receive flag cleared by hardware");
   a_hold_locked: assert property (
      st_q.ctrl[CTL_RI] && !wr_ctrl |=> $stable(st_q.hold))
      else $error("Holding register loaded while flag set");
   a_overrun_flag: assert property (
      $rose(st_q.ctrl[CTL_RI]) && $past(st_q.unread) &&
      !$past(rd && PADDR == OFS_DATA) && !$past(wr_ctrl) |->
      st_q.stat[ST_OVR])
      else $error("Overrun not flagged");
   a_irq_level: assert property (
      IRQ == |(st_q.stat & st_q.mask))
      else $error("Interrupt does not follow status and mask");
   a_sync_clock_low: assert property (
      $fell(SERIAL_OUT_PIN) && st_q.txs == TX_SYNC |->
      !SERIAL_OUT_PIN [*6] ##1 SERIAL_OUT_PIN)
      else $error("Shift clock low half is not six cycles");
   a_drive_only_sync: assert property (
      SERIAL_IN_OE |-> st_q.txs == TX_SYNC && !st_q.m0rx &&
      mode == MODE_SYNC)
      else $error("Data pin driven outside sync transmit");
   a_start_centre: assert property (
      st_q.rxs == RX_DATA && $past(st_q.rxs) == RX_START |->
      $past(st_q.rsub) == OVS_MID && !$past(rxv))
      else $error("Start bit not qualified at centre");
   a_idle_line_high: assert property (
      st_q.txs == TX_IDLE |-> SERIAL_OUT_PIN)
      else $error("Output not high while idle");

   c_rx_accept: cover property ($rose(st_q.ctrl[CTL_RI]));
   c_tx_uart: cover property (st_q.txs == TX_UART ##1 $rose(IRQ));
   c_sync_rx: cover property (st_q.m0rx && st_q.txs == TX_SYNC);
   c_overrun: cover property ($rose(st_q.stat[ST_OVR]));
endmodule
`default_nettype wire

// file: shared/serial_port_pkg.sv
// Constants and types for the four-mode serial port with APB registers.
// Assumes one core clock and 32-bit APB data with byte addresses.
package serial_port_pkg;
   // Register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_DATA = 8'h04;
   localparam logic [7:0] OFS_BAUD = 8'h08;
   localparam logic [7:0] OFS_STAT = 8'h0C;
   localparam logic [7:0] OFS_MASK = 8'h10;
   localparam logic [7:0] OFS_ADDR = 8'h14;
   localparam logic [7:0] OFS_ADEN = 8'h18;
   // Control register fields
   localparam int CTL_RI = 0;
   localparam int CTL_TI = 1;
   localparam int CTL_RB8 = 2;
   localparam int CTL_TB8 = 3;
   localparam int CTL_REN = 4;
   localparam int CTL_SM2 = 5;
   localparam int CTL_MODE = 6;
   // Status and mask fields
   localparam int ST_RX = 0;
   localparam int ST_TX = 1;
   localparam int ST_OVR = 2;
   localparam int ST_FERR = 3;
   // Rate configuration fields
   localparam int BAUD_DBL = 0;
   localparam int BAUD_TXSRC = 1;
   localparam int BAUD_RXSRC = 2;
   // Values after reset
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [2:0] BAUD_RST = 3'h0;
   localparam logic [3:0] STAT_RST = 4'h0;
   localparam logic [7:0] ADDR_RST = 8'h00;
   // Cycle counts
   localparam int OVS = 16;
   localparam logic [3:0] OVS_MID = 4'h7;
   localparam logic [3:0] OVS_LAST = 4'(OVS - 1);
   localparam int M0_DIV = 12;
   localparam logic [3:0] M0_LAST = 4'(M0_DIV - 1);
   localparam logic [3:0] M0_HALF = 4'(M0_DIV / 2);
   localparam logic [3:0] M0_BITS_LAST = 4'h7;
   localparam int CORE_PER_BIT_SLOW = 64;
   localparam int CORE_PER_BIT_FAST = 32;
   localparam logic [2:0] FIX_TICK_SLOW = 3'(CORE_PER_BIT_SLOW / OVS);
   localparam logic [2:0] FIX_TICK_FAST = 3'(CORE_PER_BIT_FAST / OVS);
   localparam logic [2:0] T1_OVF_SLOW = 3'h2;
   localparam logic [2:0] T1_OVF_FAST = 3'h1;
   localparam logic [2:0] T234_OVF = 3'h1;
   localparam logic [3:0] TX_PRE8 = 4'h9;
   localparam logic [3:0] TX_PRE9 = 4'hA;
   localparam logic [3:0] RX_DATA8 = 4'h8;
   localparam logic [3:0] RX_DATA9 = 4'h9;
   typedef enum logic [1:0] {MODE_SYNC, MODE_UART8, MODE_UART9F,
                             MODE_UART9V} mode_t;
   typedef enum {TX_IDLE, TX_UART, TX_SYNC} tx_state_t;
   typedef enum {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;
endpackage

// file: shared/tick_if.sv
// Link between the port core and its oversample tick generators.
// Assumes every signal runs on the core clock.
`timescale 1ns/1ps
`default_nettype none
interface tick_if;
   logic t1_ovf;
   logic t234_ovf;
   logic fixed_rate;
   logic src_sel;
   logic dbl;
   logic tick;
   modport gen (input t1_ovf, input t234_ovf, input fixed_rate,
                input src_sel, input dbl, output tick);
   modport user (output t1_ovf, output t234_ovf, output fixed_rate,
                 output src_sel, output dbl, input tick);
endinterface
`default_nettype wire

// file: rtl/line_sync.sv
// Three-stage synchroniser for the serial input pin.
// Assumes an idle-high line; output follows once stages two and three agree.
`timescale 1ns/1ps
`default_nettype none
module line_sync
(
   input wire logic clk, // Core clock
   input wire logic rst_n, // Asynchronous reset, active low
   input wire logic pin, // Raw pin level
   output logic level // Filtered level
);
   typedef struct packed {logic s1; logic s2; logic s3; logic lvl;} ls_t;
   ls_t st_q;
   ls_t st_d;

   assign level = st_q.lvl;

   always_comb
   begin
      st_d = st_q;
      st_d.s1 = pin;
      st_d.s2 = st_q.s1;
      st_d.s3 = st_q.s2;
      if (st_q.s2 == st_q.s3)
         st_d.lvl = st_q.s3;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         st_q <= '1;
      else
         st_q <= st_d;
   end
endmodule
`default_nettype wire

// file: rtl/tick_gen.sv
// Oversample tick generator, sixteen ticks per bit time.
// Assumes timer overflow inputs are one-cycle pulses on the core clock.
`timescale 1ns/1ps
`default_nettype none
module tick_gen
   import serial_port_pkg::*;
(
   input wire logic clk, // Core clock
   input wire logic rst_n, // Asynchronous reset, active low
   tick_if.gen tif // Rate choice in, tick out
);
   typedef struct packed {logic [2:0] cnt; logic tick;} tg_t;
   tg_t st_q;
   tg_t st_d;
   logic ev;
   logic [2:0] lim;

   assign tif.tick = st_q.tick;

   always_comb
   begin
      st_d = st_q;
      st_d.tick = 1'b0;
      if (tif.fixed_rate)
      begin
         ev = 1'b1;
         lim = tif.dbl ? FIX_TICK_FAST : FIX_TICK_SLOW;
      end
      else if (tif.src_sel)
      begin
         ev = tif.t234_ovf;
         lim = T234_OVF;
      end
      else
      begin
         ev = tif.t1_ovf;
         lim = tif.dbl ? T1_OVF_FAST : T1_OVF_SLOW;
      end
      if (ev)
      begin
         st_d.cnt = st_q.cnt + 3'h1;
         if (st_q.cnt + 3'h1 >= lim)
         begin
            st_d.cnt = 3'h0;
            st_d.tick = 1'b1;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         st_q <= '0;
      else
         st_q <= st_d;
   end
endmodule
`default_nettype wire

// file: bench/uart_peer.sv
// Far-side serial device: takes frames from the port's transmit pin and
// sends frames toward its input pin. Assumes BIT_CYC clocks per bit.
`timescale 1ns/1ps
`default_nettype none
module uart_peer
#(
   parameter int BIT_CYC = 16
)
(
   input wire logic clk, // Core clock
   input wire logic line_in, // Port transmit pin
   output logic line_out, // Level offered to the port input pin
   output logic [7:0] got, // Last byte received
   output int n_got // Frames received
);
   initial
   begin
      line_out = 1'b1;
      got = 8'h00;
      n_got = 0;
   end
   ////////////////////////////////////////////////////////////////////////
   // Sampling at bit centre tolerates a few cycles of start skew
   always
   begin
      @(negedge line_in);
      repeat (BIT_CYC / 2) @(posedge clk);
      for (int i = 0; i < 8; i++)
      begin
         repeat (BIT_CYC) @(posedge clk);
         got[i] = line_in;
      end
      repeat (BIT_CYC) @(posedge clk);
      n_got++;
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic send(input logic [7:0] d, input logic stop);
      logic [9:0] f;
      f = {stop, d, 1'b0};
      for (int i = 0; i < 10; i++)
      begin
         @(posedge clk);
         line_out <= f[i];
         repeat (BIT_CYC - 1) @(posedge clk);
      end
      @(posedge clk);
      line_out <= 1'b1;
   endtask
endmodule
`default_nettype wire

// file: bench/sync_async_serial_port_test.sv
// Self-checking bench: APB register tasks and mode 1 traffic with a peer.
// Assumes the timer 2/3/4 overflow input pulses every core clock.
`timescale 1ns/1ps
`default_nettype none
module sync_async_serial_port_test
   import serial_port_pkg::*;
();
   logic ref_clk;
   logic resetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready, pslverr, in_out, in_oe, out_pin, irq, peer_line;
   logic [7:0] peer_got;
   int peer_n;
   int n_fail = 0;
   int n_tests = 0;
   // Open-drain data pin with pull-up
   wire logic in_pin = in_oe ? 1'b0 : peer_line;
   serial_port_top u_dut (.REF_CLK(ref_clk), .RESETN(resetn), .PSEL(psel),
      .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
      .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .TIMER1_OVF(1'b0), .TIMER234_OVF(1'b1), .SERIAL_IN_PIN(in_pin),
      .SERIAL_IN_OUT(in_out), .SERIAL_IN_OE(in_oe),
      .SERIAL_OUT_PIN(out_pin), .IRQ(irq));
   uart_peer #(.BIT_CYC(OVS)) u_peer (.clk(ref_clk), .line_in(out_pin),
      .line_out(peer_line), .got(peer_got), .n_got(peer_n));
   initial
   begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         n_fail++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] wd, output logic [31:0] rd,
                      output logic er);
      @(posedge ref_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge ref_clk);
      penable <= 1'b1;
      // Values read at the edge are the ones launched by the previous edge
      do
      begin
         @(posedge ref_clk);
      end
      while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] rd;
      logic er;
      apb(1'b1, a, d, rd, er);
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] rd;
      logic er;
      apb(1'b0, a, 32'h0, rd, er);
      chk(rd, exp);
   endtask
   task automatic wait_tx(input int n);
      for (int k = 0; k < 500 && peer_n != n; k++)
         @(posedge ref_clk);
   endtask
   // Mode 0 far side: data pin is taken at each rising shift clock
   task automatic m0_get(output logic [7:0] d);
      for (int i = 0; i < 8; i++)
      begin
         @(posedge out_pin);
         d[i] = in_pin;
      end
   endtask
   // Covers input synchroniser and flag update latency
   task automatic settle();
      repeat (40) @(posedge ref_clk);
   endtask
   task automatic done(input string s);
      $display("test done: %s", s);
   endtask
   task automatic summarize();
      $display("comparisons %0d, mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   // About 1540 cycles are needed; thirteen times that means a hang
   initial
   begin
      repeat (20000) @(posedge ref_clk);
      n_fail++;
      summarize();
   end
   initial
   begin
      logic [31:0] rd;
      logic er;
      repeat (6) @(posedge ref_clk);
      resetn <= 1'b1;
      rd_chk(OFS_CTRL, 32'(CTRL_RST));
      rd_chk(OFS_STAT, 32'(STAT_RST));
      rd_chk(OFS_BAUD, 32'(BAUD_RST));
      apb(1'b0, 8'h1C, 32'h0, rd, er);
      chk({31'h0, er}, 32'h1);
      chk(rd, 32'h0);
      done("reset and map");
      wr(OFS_BAUD, 32'h6);
      wr(OFS_MASK, 32'h3);
      wr(OFS_CTRL, 32'h50);
      wr(OFS_DATA, 32'hA5);
      wait_tx(1);
      chk({24'h0, peer_got}, 32'hA5);
      chk({31'h0, irq}, 32'h1);
      rd_chk(OFS_STAT, 32'h2);
      rd_chk(OFS_STAT, 32'h0);
      rd_chk(OFS_CTRL, 32'h52);
      wr(OFS_CTRL, 32'h50);
      rd_chk(OFS_CTRL, 32'h50);
      done("transmit");
      u_peer.send(8'h3C, 1'b1);
      settle();
      chk({31'h0, irq}, 32'h1);
      rd_chk(OFS_CTRL, 32'h55);
      rd_chk(OFS_DATA, 32'h3C);
      rd_chk(OFS_STAT, 32'h1);
      done("receive");
      wr(OFS_CTRL, 32'h50);
      u_peer.send(8'h11, 1'b1);
      settle();
      wr(OFS_CTRL, 32'h50);
      u_peer.send(8'h22, 1'b1);
      settle();
      rd_chk(OFS_STAT, 32'h5);
      rd_chk(OFS_DATA, 32'h22);
      u_peer.send(8'h77, 1'b1);
      settle();
      rd_chk(OFS_DATA, 32'h22);
      wr(OFS_CTRL, 32'h70);
      u_peer.send(8'h99, 1'b0);
      settle();
      rd_chk(OFS_DATA, 32'h22);
      rd_chk(OFS_STAT, 32'h8);
      done("overrun and load checks");
      wr(OFS_CTRL, 32'h00);
      wr(OFS_DATA, 32'h5A);
      m0_get(rd[7:0]);
      chk({24'h0, rd[7:0]}, 32'h5A);
      settle();
      rd_chk(OFS_CTRL, 32'h06);
      chk({31'h0, in_out}, 32'h0);
      done("sync transmit");
      wr(OFS_CTRL, 32'h10);
      repeat (3) settle();
      rd_chk(OFS_CTRL, 32'h15);
      rd_chk(OFS_DATA, 32'hFF);
      rd_chk(OFS_STAT, 32'h3);
      done("sync receive");
      summarize();
   end
endmodule
`default_nettype wire
